//--- src/erti_defs.vh
// Constants for the encoder range teach-in block
`ifndef ERTI_DEFS_VH
`define ERTI_DEFS_VH

// Position word: whole turns above, angle within a turn below
`define ERTI_TURN_BITS   15
`define ERTI_ANGLE_BITS  12
`define ERTI_POS_BITS    27
`define ERTI_CODE_BITS   12
`define ERTI_CODE_MAX    12'hfff

// Factory setting: zero at 0, final at 10 turns, counting clockwise
`define ERTI_DEF_TURNS   15'h000a
`define ERTI_DEF_ZERO    27'h0000000
`define ERTI_DEF_SENSE   1'b0

// Timing
`define ERTI_CLK_KHZ     100000
`define ERTI_HOLD_MS     1500
`define ERTI_SKEW_US     1000
`define ERTI_CNT_BITS    28

// Teach-in states
`define ERTI_ST_IDLE     3'h0
`define ERTI_ST_ZERO     3'h1
`define ERTI_ST_FINAL    3'h2
`define ERTI_ST_BOTH     3'h3
`define ERTI_ST_RELEASE  3'h4

`endif

//--- src/erti_sync.v
// Two-flop synchroniser for the mode pins, idle high
`timescale 1ns/1ps
`default_nettype none

module erti_sync #(
  parameter WIDTH = 2
) (
  input  wire             clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta;
      reg stable;
      // Reset high so an idle pin never looks like a press
      always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta   <= 1'b1;
          stable <= 1'b1;
        end else begin
          meta   <= async_i[g];
          stable <= meta;
        end
      end
      assign sync_o[g] = stable;
    end
  endgenerate

endmodule // erti_sync

`default_nettype wire

//--- src/erti_scale.v
// Range region check and 12-bit scaling divider
`include "erti_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module erti_scale (
  input  wire                       clk_i,
  input  wire                       rst_b_i,
  input  wire [`ERTI_POS_BITS-1:0]  rel_i,
  input  wire [`ERTI_POS_BITS-1:0]  span_i,
  output reg  [`ERTI_CODE_BITS-1:0] code_o,
  output reg                        overflow_o,
  output reg                        underflow_o
);

  reg  [`ERTI_POS_BITS-1:0] rel_q;
  reg  [`ERTI_POS_BITS-1:0] span_q;
  reg  [`ERTI_POS_BITS:0]   rem;
  reg  [`ERTI_CODE_BITS-1:0] quo;
  reg  [3:0]                step;
  wire [`ERTI_POS_BITS:0]   span_w = {1'b0, span_q};
  wire [`ERTI_POS_BITS:0]   outside = {1'b1, {`ERTI_POS_BITS{1'b0}}} - span_w;
  wire [`ERTI_POS_BITS:0]   ovf_lim = span_w + {1'b0, outside[`ERTI_POS_BITS:1]};
  wire [`ERTI_POS_BITS:0]   shifted = {rem[`ERTI_POS_BITS-1:0], 1'b0};
  wire                      take = (shifted >= span_w);
  wire [`ERTI_CODE_BITS-1:0] quo_next = {quo[`ERTI_CODE_BITS-2:0], take};
  wire                      in_range = (rel_q <= span_q);
  wire                      in_ovf = !in_range && ({1'b0, rel_q} <= ovf_lim);

  // One result every 13 clocks; position changes far slower than that
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rel_q       <= {`ERTI_POS_BITS{1'b0}};
      span_q      <= {`ERTI_POS_BITS{1'b0}};
      rem         <= {(`ERTI_POS_BITS+1){1'b0}};
      quo         <= {`ERTI_CODE_BITS{1'b0}};
      step        <= 4'h0;
      code_o      <= {`ERTI_CODE_BITS{1'b0}};
      overflow_o  <= 1'b0;
      underflow_o <= 1'b0;
    end else if (step == 4'h0) begin
      rel_q  <= rel_i;
      span_q <= span_i;
      rem    <= {1'b0, rel_i};
      quo    <= {`ERTI_CODE_BITS{1'b0}};
      step   <= 4'h1;
    end else begin
      rem  <= take ? (shifted - span_w) : shifted;
      quo  <= quo_next;
      step <= (step == 4'hc) ? 4'h0 : step + 4'h1;
      if (step == 4'hc) begin
        overflow_o  <= in_ovf;
        underflow_o <= !in_range && !in_ovf;
        if (in_ovf)
          code_o <= `ERTI_CODE_MAX;
        else if (in_range && span_q != {`ERTI_POS_BITS{1'b0}})
          code_o <= quo_next;
        else
          code_o <= {`ERTI_CODE_BITS{1'b0}};
      end
    end
  end

endmodule // erti_scale

`default_nettype wire

//--- src/erti_top.v
// Encoder range teach-in: zero, final value and code sense from two mode pins
`include "erti_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module erti_top #(
  parameter HOLD_CYCLES = `ERTI_HOLD_MS * `ERTI_CLK_KHZ,
  parameter SKEW_CYCLES = `ERTI_SKEW_US * (`ERTI_CLK_KHZ / 1000)
) (
  input  wire                       clk_i,
  input  wire                       rst_b_i,
  input  wire [`ERTI_POS_BITS-1:0]  position_i,
  input  wire                       mode0_b_i,
  input  wire                       mode1_b_i,
  output wire [`ERTI_CODE_BITS-1:0] code_o,
  output wire                       overflow_o,
  output wire                       underflow_o,
  output wire                       sense_ccw_o,
  output wire [`ERTI_POS_BITS-1:0]  zero_pos_o,
  output wire [`ERTI_POS_BITS-1:0]  final_pos_o,
  output wire                       adjusting_o,
  output wire                       taught_o
);

  // Counter holds the largest hold count, so cut the 32-bit sums on purpose
  localparam integer              HOLD_M1   = HOLD_CYCLES - 1;
  localparam integer              SKEW_M1   = SKEW_CYCLES - 1;
  localparam [`ERTI_CNT_BITS-1:0] HOLD_LAST = HOLD_M1[`ERTI_CNT_BITS-1:0];
  localparam [`ERTI_CNT_BITS-1:0] SKEW_LAST = SKEW_M1[`ERTI_CNT_BITS-1:0];
  localparam [`ERTI_POS_BITS-1:0] DEF_FINAL =
    {`ERTI_DEF_TURNS, {`ERTI_ANGLE_BITS{1'b0}}};

  // Pins come from the switch box, so synchronise first
  wire [1:0] mode_b;

  erti_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i ({mode1_b_i, mode0_b_i}),
    .sync_o  (mode_b)
  );

  wire m0_low = !mode_b[0];
  wire m1_low = !mode_b[1];

  reg [2:0]                state;
  reg [2:0]                next_state;
  reg [`ERTI_CNT_BITS-1:0] cnt;
  reg [`ERTI_CNT_BITS-1:0] next_cnt;
  reg [`ERTI_POS_BITS-1:0] zero_pos;
  reg [`ERTI_POS_BITS-1:0] final_pos;
  reg                      sense_ccw;
  reg                      zero_fresh;
  reg                      taught;
  reg                      do_zero;
  reg                      do_final;
  reg                      do_restore;

  wire hold_done = (cnt == HOLD_LAST);
  wire in_skew   = (cnt <= SKEW_LAST);

  // Teach-in sequencer
  always @* begin
    next_state = state;
    next_cnt   = cnt + {{(`ERTI_CNT_BITS-1){1'b0}}, 1'b1};
    do_zero    = 1'b0;
    do_final   = 1'b0;
    do_restore = 1'b0;
    case (state)
      `ERTI_ST_IDLE: begin
        next_cnt = {`ERTI_CNT_BITS{1'b0}};
        if (m0_low && m1_low)
          next_state = `ERTI_ST_BOTH;
        else if (m0_low)
          next_state = `ERTI_ST_ZERO;
        else if (m1_low)
          next_state = `ERTI_ST_FINAL;
      end
      `ERTI_ST_ZERO: begin
        if (!m0_low) begin
          next_state = `ERTI_ST_IDLE;
        end else if (m1_low) begin
          // Second pin too late means no valid command at all
          next_state = in_skew ? `ERTI_ST_BOTH : `ERTI_ST_RELEASE;
          next_cnt   = {`ERTI_CNT_BITS{1'b0}};
        end else if (hold_done) begin
          do_zero    = 1'b1;
          next_state = `ERTI_ST_RELEASE;
        end
      end
      `ERTI_ST_FINAL: begin
        if (!m1_low) begin
          next_state = `ERTI_ST_IDLE;
        end else if (m0_low) begin
          next_state = in_skew ? `ERTI_ST_BOTH : `ERTI_ST_RELEASE;
          next_cnt   = {`ERTI_CNT_BITS{1'b0}};
        end else if (hold_done) begin
          do_final   = 1'b1;
          next_state = `ERTI_ST_RELEASE;
        end
      end
      `ERTI_ST_BOTH: begin
        // Letting one pin go must not turn into a single-pin command
        if (!m0_low || !m1_low) begin
          next_state = `ERTI_ST_RELEASE;
        end else if (hold_done) begin
          do_restore = 1'b1;
          next_state = `ERTI_ST_RELEASE;
        end
      end
      `ERTI_ST_RELEASE: begin
        next_cnt = {`ERTI_CNT_BITS{1'b0}};
        if (!m0_low && !m1_low)
          next_state = `ERTI_ST_IDLE;
      end
      default: begin
        next_state = `ERTI_ST_IDLE;
        next_cnt   = {`ERTI_CNT_BITS{1'b0}};
      end
    endcase
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= `ERTI_ST_IDLE;
      cnt   <= {`ERTI_CNT_BITS{1'b0}};
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Mirror of the old final about the zero keeps the span on a sense flip
  wire [`ERTI_POS_BITS-1:0] mirror_final = {zero_pos[`ERTI_POS_BITS-2:0], 1'b0} - final_pos;

  // Range settings; position arithmetic wraps over the full span
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zero_pos   <= `ERTI_DEF_ZERO;
      final_pos  <= DEF_FINAL;
      sense_ccw  <= `ERTI_DEF_SENSE;
      zero_fresh <= 1'b0;
      taught     <= 1'b0;
    end else begin
      taught <= do_zero || do_final || do_restore;
      if (do_restore) begin
        zero_pos   <= `ERTI_DEF_ZERO;
        final_pos  <= DEF_FINAL;
        sense_ccw  <= `ERTI_DEF_SENSE;
        zero_fresh <= 1'b0;
      end else if (do_zero) begin
        // Taken in any region, so a lost range can be found again
        zero_pos   <= position_i;
        zero_fresh <= 1'b1;
      end else if (do_final) begin
        zero_fresh <= 1'b0;
        if (zero_fresh && position_i == zero_pos) begin
          sense_ccw <= !sense_ccw;
          final_pos <= mirror_final;
        end else begin
          final_pos <= position_i;
        end
      end
    end
  end

  // Distance from zero along the chosen sense, modulo 32768 turns
  wire [`ERTI_POS_BITS-1:0] rel = sense_ccw ? (zero_pos - position_i)
                                            : (position_i - zero_pos);
  wire [`ERTI_POS_BITS-1:0] span = sense_ccw ? (zero_pos - final_pos)
                                             : (final_pos - zero_pos);

  erti_scale u_scale (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .rel_i       (rel),
    .span_i      (span),
    .code_o      (code_o),
    .overflow_o  (overflow_o),
    .underflow_o (underflow_o)
  );

  assign sense_ccw_o = sense_ccw;
  assign zero_pos_o  = zero_pos;
  assign final_pos_o = final_pos;
  assign adjusting_o = (state != `ERTI_ST_IDLE);
  assign taught_o    = taught;

endmodule // erti_top

`default_nettype wire

//--- verification/erti_props.sv
// Assertion checker bound to the teach-in top
`timescale 1ns/1ps
`default_nettype none
module erti_props #(
  parameter HOLD_CYCLES = 150000000,
  parameter SKEW_CYCLES = 100000
) (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [26:0] position_i,
  input wire logic        mode0_b_i,
  input wire logic        mode1_b_i,
  input wire logic [11:0] code_o,
  input wire logic        overflow_o,
  input wire logic        underflow_o,
  input wire logic        sense_ccw_o,
  input wire logic [26:0] zero_pos_o,
  input wire logic [26:0] final_pos_o,
  input wire logic        adjusting_o,
  input wire logic        taught_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_OVF_FULL: assert property (overflow_o |-> code_o == 12'hfff)
    else $error("code not full scale in overflow");
  AST_UNF_ZERO: assert property (underflow_o |-> code_o == 12'h000)
    else $error("code not zero in underflow");
  AST_ONE_REGION: assert property (!(overflow_o && underflow_o))
    else $error("overflow and underflow together");
  AST_PULSE: assert property (taught_o |=> !taught_o)
    else $error("command pulse longer than one cycle");
  AST_SET_TAUGHT: assert property (($changed(zero_pos_o) || $changed(final_pos_o)
    || $changed(sense_ccw_o)) |-> adjusting_o && taught_o)
    else $error("setting changed outside a command");
  // Restore may also move the zero, hence the second choice
  AST_ZERO_POS: assert property ($changed(zero_pos_o) |->
    zero_pos_o == $past(position_i) || zero_pos_o == 27'h0000000)
    else $error("zero not taken from position");
  AST_END_ADJ: assert property ((mode0_b_i && mode1_b_i)[*5] |-> !adjusting_o)
    else $error("adjustment not ended with both pins high");
  AST_NO_EARLY: assert property (($fell(mode0_b_i) || $fell(mode1_b_i)) && !adjusting_o
    |=> !taught_o[*8])
    else $error("command acted before the hold time");
endmodule // erti_props
bind erti_top erti_props #(.HOLD_CYCLES(HOLD_CYCLES), .SKEW_CYCLES(SKEW_CYCLES)) i_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .position_i(position_i), .mode0_b_i(mode0_b_i),
  .mode1_b_i(mode1_b_i), .code_o(code_o), .overflow_o(overflow_o), .underflow_o(underflow_o),
  .sense_ccw_o(sense_ccw_o), .zero_pos_o(zero_pos_o), .final_pos_o(final_pos_o),
  .adjusting_o(adjusting_o), .taught_o(taught_o));
`default_nettype wire

//--- verification/erti_user.sv
// Model of the user's teach-in switches on the two mode pins
`timescale 1ns/1ps
`default_nettype none
module erti_user (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [1:0] low_i,
  input  wire logic [8:0] len_i,
  input  wire logic [8:0] skew_i,
  output var  logic       busy_o,
  output var  logic       mode0_b_o,
  output var  logic       mode1_b_o
);
  logic [8:0] cnt;
  initial {busy_o, mode0_b_o, mode1_b_o, cnt} = 12'h600;
  always @(posedge clk_i) begin
    if (!busy_o) begin
      busy_o <= go_i;
      cnt    <= 9'h000;
    end else begin
      cnt       <= cnt + 9'h001;
      // Second pin lags by skew, so a late press can be shown
      mode0_b_o <= !(low_i[0] && cnt < len_i);
      mode1_b_o <= !(low_i[1] && cnt >= skew_i && cnt < skew_i + len_i);
      // Both high for a while before done, so the device is idle again
      busy_o    <= cnt != len_i + skew_i + 9'h008;
    end
  end
endmodule // erti_user
`default_nettype wire

//--- verification/encoder_range_teach_in_tb.sv
// Self-checking bench for the teach-in top
`timescale 1ns/1ps
`default_nettype none
module encoder_range_teach_in_tb;
  logic        clk_i, rst_b_i, go, busy, m0, m1, sense, adj, taught, ovf, unf;
  logic [26:0] pos, zero, fin;
  logic [11:0] code;
  logic [1:0]  low;
  logic [8:0]  len, skew;
  integer      err_count, n_checks, n_taught, cyc;

  erti_top #(.HOLD_CYCLES(40), .SKEW_CYCLES(8)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .position_i(pos), .mode0_b_i(m0), .mode1_b_i(m1),
    .code_o(code), .overflow_o(ovf), .underflow_o(unf), .sense_ccw_o(sense),
    .zero_pos_o(zero), .final_pos_o(fin), .adjusting_o(adj), .taught_o(taught));
  erti_user i_user (.clk_i(clk_i), .go_i(go), .low_i(low), .len_i(len), .skew_i(skew),
    .busy_o(busy), .mode0_b_o(m0), .mode1_b_o(m1));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (taught === 1'b1) n_taught = n_taught + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Over two scaler periods, so the code reflects the new position
  task automatic at(input logic [26:0] p, input logic [11:0] c, input logic o, input logic u);
    pos <= p;
    repeat (30) @(posedge clk_i);
    check({code, ovf, unf}, {c, o, u});
  endtask

  task automatic setting(input logic s, input logic [26:0] z, input logic [26:0] f);
    check({sense, zero, fin}, {s, z, f});
  endtask

  task automatic press(input logic [1:0] m, input logic [8:0] l, input logic [8:0] s,
                       input integer n);
    integer k;
    k = 0;
    low <= m;
    len <= l;
    skew <= s;
    go <= 1'b1;
    repeat (2) @(posedge clk_i);
    go <= 1'b0;
    while (busy === 1'b1 && k < 500) begin
      @(posedge clk_i);
      k = k + 1;
    end
    check(n_taught, n);
    check(adj, 1'b0);
  endtask

  task stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    rst_b_i = 1'b0;
    pos = 27'h0000000;
    {go, low, len, skew} = 21'h000000;
    {err_count, n_checks, n_taught, cyc} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    at(27'h0005000, 12'h800, 1'b0, 1'b0);
    setting(1'b0, 27'h0000000, 27'h000a000);
    at(27'h000a000, 12'hfff, 1'b0, 1'b0);
    at(27'h4005000, 12'hfff, 1'b1, 1'b0);
    at(27'h4005001, 12'h000, 1'b0, 1'b1);
    press(2'b01, 9'h014, 9'h000, 0);
    press(2'b01, 9'h03c, 9'h000, 1);
    setting(1'b0, 27'h4005001, 27'h000a000);
    pos <= 27'h4008001;
    press(2'b10, 9'h03c, 9'h000, 2);
    at(27'h4006001, 12'h555, 1'b0, 1'b0);
    press(2'b01, 9'h03c, 9'h000, 3);
    press(2'b10, 9'h03c, 9'h000, 4);
    setting(1'b1, 27'h4006001, 27'h4004001);
    at(27'h4005001, 12'h800, 1'b0, 1'b0);
    // Second pin too late: must be ignored
    press(2'b11, 9'h03c, 9'h014, 4);
    press(2'b11, 9'h03c, 9'h002, 5);
    setting(1'b0, 27'h0000000, 27'h000a000);
    press(2'b11, 9'h03c, 9'h000, 6);
    setting(1'b0, 27'h0000000, 27'h000a000);
    stop_test;
  end
endmodule // encoder_range_teach_in_tb
`default_nettype wire
